/* pvc_pkg.sv */
package pvc_pkg;
   // Register byte offsets.
   localparam logic [5:0]  REG_MODE      = 6'h00;
   localparam logic [5:0]  REG_SYNC      = 6'h04;
   localparam logic [5:0]  REG_HTIM      = 6'h08;
   localparam logic [5:0]  REG_VTIM      = 6'h0c;
   localparam logic [5:0]  REG_ACT       = 6'h10;
   localparam logic [5:0]  REG_VSTART    = 6'h14;
   localparam logic [5:0]  REG_FMT       = 6'h18;
   localparam logic [5:0]  REG_EMB       = 6'h1c;
   localparam logic [5:0]  REG_BASE      = 6'h20;
   localparam logic [5:0]  REG_LOFF      = 6'h24;
   localparam logic [5:0]  REG_FOFF      = 6'h28;
   localparam logic [5:0]  REG_STAT      = 6'h2c;
   localparam logic [31:0] RST_REG       = 32'h0000_0000;
   // Bits of capture_mode_control.
   localparam int          MODE_SYNC_DIR = 0;
   localparam int          MODE_VS_INV   = 1;
   localparam int          MODE_HS_INV   = 2;
   localparam int          MODE_FI_INV   = 3;
   localparam int          MODE_FI_DIR   = 4;
   localparam int          MODE_WEN_EN   = 5;
   localparam int          MODE_ILACE    = 6;
   localparam int          MODE_DATA_INV = 7;
   localparam int          MODE_FI_LATCH = 8;
   localparam int          MODE_PIXEL_CLOCK_EDGE_INVERT = 9;
   // Bits of sync_enable_control.
   localparam int          SYNC_GEN_EN   = 0;
   localparam int          SYNC_MEMORY_WRITE_ENABLE     = 1;
   // Bits of embedded_sync_control.
   localparam int          EMB_ON        = 0;
   localparam int          EMB_ECC       = 1;
   localparam int          EMB_W10       = 2;
   // Format register: raw_width_shift in [2:0], memory_pack_mode in [5:4].
   localparam int          FMT_PACK_LSB  = 4;
   localparam logic [1:0]  PACK_HALF     = 2'h0;
   localparam logic [1:0]  PACK_12       = 2'h1;
   localparam logic [1:0]  PACK_8        = 2'h2;
   localparam logic [5:0]  PW_8          = 6'h08;
   localparam logic [5:0]  PW_12         = 6'h0c;
   localparam logic [5:0]  PW_16         = 6'h10;
   localparam logic [5:0]  BITS_WORD     = 6'h20;
   localparam int          BURST_WORDS   = 8;
   localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
   // Timing reference codes and flag-error syndromes.
   localparam logic [7:0]  TRS_FF        = 8'hff;
   localparam logic [7:0]  TRS_00        = 8'h00;
   localparam logic [3:0]  SYN_F         = 4'h7;
   localparam logic [3:0]  SYN_V         = 4'hb;
   localparam logic [3:0]  SYN_H         = 4'hd;
endpackage : pvc_pkg

/* pvc_trs_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pvc_trs_if;
   logic [7:0] code;
   logic       valid;
   logic       ecc_en;
   logic       f;
   logic       v;
   logic       h;
   logic       sav;
   logic       eav;
   modport dec (input code, input valid, input ecc_en,
                output f, output v, output h, output sav, output eav);
   modport cap (output code, output valid, output ecc_en,
                input f, input v, input h, input sav, input eav);
endinterface : pvc_trs_if
`default_nettype wire

/* pvc_trs_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_trs_decoder (
   input  wire logic clk,
   input  wire logic rst,
   pvc_trs_if.dec    trs
);
   typedef enum logic [1:0] {
      PVC_TRS_IDLE = 2'b00,
      PVC_TRS_FF   = 2'b01,
      PVC_TRS_Z1   = 2'b10,
      PVC_TRS_Z2   = 2'b11
   } pvc_trs_st_t;

   typedef struct packed {
      pvc_trs_st_t st;
      logic        f;
      logic        v;
      logic        h;
      logic        sav;
      logic        eav;
   } pvc_dec_t;

   pvc_dec_t s;
   pvc_dec_t n;

   function automatic logic [3:0] pvc_prot(input logic f, input logic v, input logic h);
      pvc_prot = {v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction : pvc_prot

   always_comb begin
      logic       fn;
      logic       vn;
      logic       hn;
      logic [3:0] syn;
      fn = trs.code[6];
      vn = trs.code[5];
      hn = trs.code[4];
      syn = trs.code[3:0] ^ pvc_prot(trs.code[6], trs.code[5], trs.code[4]);
      n = s;
      n.sav = 1'b0;
      n.eav = 1'b0;
      if (trs.ecc_en) begin
         unique case (syn)
            pvc_pkg::SYN_F: fn = !fn;
            pvc_pkg::SYN_V: vn = !vn;
            pvc_pkg::SYN_H: hn = !hn;
            default: ;
         endcase
      end
      if (trs.valid) begin
         unique case (s.st)
            PVC_TRS_IDLE: n.st = (trs.code == pvc_pkg::TRS_FF) ? PVC_TRS_FF : PVC_TRS_IDLE;
            PVC_TRS_FF, PVC_TRS_Z1: begin
               if (trs.code == pvc_pkg::TRS_00) begin
                  n.st = (s.st == PVC_TRS_FF) ? PVC_TRS_Z1 : PVC_TRS_Z2;
               end else begin
                  n.st = (trs.code == pvc_pkg::TRS_FF) ? PVC_TRS_FF : PVC_TRS_IDLE;
               end
            end
            PVC_TRS_Z2: begin
               n.st = PVC_TRS_IDLE;
               if (trs.code[7]) begin
                  n.f = fn;
                  n.v = vn;
                  n.h = hn;
                  n.sav = !hn;
                  n.eav = hn;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign trs.f = s.f;
   assign trs.v = s.v;
   assign trs.h = s.h;
   assign trs.sav = s.sav;
   assign trs.eav = s.eav;

   property p_trs_preamble;
      @(posedge clk) disable iff (rst)
      (trs.sav || trs.eav) |-> ($past(s.st) == PVC_TRS_Z2) && $past(trs.valid);
   endproperty
   a_trs_preamble: assert property (p_trs_preamble) else $error("code seen without preamble");

   property p_trs_flag;
      @(posedge clk) disable iff (rst)
      (trs.sav || trs.eav) |-> (trs.h == trs.eav) && !(trs.sav && trs.eav);
   endproperty
   a_trs_flag: assert property (p_trs_flag) else $error("start or end flag mismatch");

   property p_trs_ecc;
      @(posedge clk) disable iff (rst)
      (trs.valid && trs.ecc_en && s.st == PVC_TRS_Z2 && trs.code == 8'ha0)
         |=> trs.sav && !trs.v && !trs.f;
   endproperty
   a_trs_ecc: assert property (p_trs_ecc) else $error("vertical flag error not corrected");

   property p_trs_prot;
      @(posedge clk) disable iff (rst)
      (trs.valid && trs.ecc_en && s.st == PVC_TRS_Z2 && trs.code == 8'hc7)
         |=> trs.f && !trs.v && !trs.h && trs.sav;
   endproperty
   a_trs_prot: assert property (p_trs_prot) else $error("clean code was altered");
endmodule : pvc_trs_decoder
`default_nettype wire

/* pvc_capture.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Output mode generates syncs from programmed timing.
// - Separate invert for vsync, hsync, field.
// - Data invert flips every incoming data bit.
// - Field pin direction chosen by control bit.
// - Field input optionally latched at vsync edge.
// - Write enable input gates stored pixels.
// - Pixel clock edge selected by invert bit.
// - Separate vertical start for even, odd fields.
// - Unpacked raw: right shift, low halfword bits.
// - Eight-bit pack: four pixels per word.
// - Twelve-bit pack: eight pixels in three words.
// - FIFO drains to memory in 32-byte bursts.
// - Memory writes only while write enable set.
// - Lines placed at programmable line offsets.
// - Embedded mode derives syncs from timing codes.
// - Embedded data eight or ten bits wide.
// - Capture starts after hsync, programmable length.
// - Timing code: FF 00 00 then status.
// - Status flags: field, vertical blank, start/end.
// - Optional correction of flags by protection bits.
module pvc_capture #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        pclk_pin,
   input  wire logic [15:0] data_pin,
   input  wire logic        vsync_pin,
   output logic             vsync_drive,
   output logic             vsync_drive_en,
   input  wire logic        hsync_pin,
   output logic             hsync_drive,
   output logic             hsync_drive_en,
   input  wire logic        wen_field_pin,
   output logic             field_drive,
   output logic             field_drive_en,
   output logic             mem_valid,
   output logic             mem_burst_start,
   output logic      [31:0] mem_addr,
   output logic      [31:0] mem_data
);
   localparam int AW = $clog2(FIFO_DEPTH);

   typedef struct packed {
      logic [9:0]                  mode;
      logic [1:0]                  sync;
      logic [31:0]                 htim;
      logic [31:0]                 vtim;
      logic [31:0]                 act;
      logic [31:0]                 vst;
      logic [5:0]                  fmt;
      logic [2:0]                  emb;
      logic [31:0]                 base;
      logic [31:0]                 loff;
      logic [31:0]                 foff;
      logic [31:0]                 rdata;
      logic                        pc1;
      logic                        pc2;
      logic                        pc3;
      logic [15:0]                 d1;
      logic [15:0]                 d2;
      logic                        vs1;
      logic                        vs2;
      logic                        hs1;
      logic                        hs2;
      logic                        wf1;
      logic                        wf2;
      logic [15:0]                 gh;
      logic [15:0]                 gv;
      logic                        gfld;
      logic                        hs_p;
      logic                        vs_p;
      logic [15:0]                 hpos;
      logic [15:0]                 vline;
      logic                        fld_lat;
      logic [47:0]                 acc;
      logic [5:0]                  bits;
      logic [31:0]                 laddr;
      logic [31:0]                 waddr;
      logic                        lhad;
      logic [FIFO_DEPTH-1:0][63:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        bact;
      logic [2:0]                  bcnt;
      logic                        mv;
      logic                        mbs;
      logic [31:0]                 maddr;
      logic [31:0]                 mdata;
      logic                        vs_o;
      logic                        vs_oe;
      logic                        hs_o;
      logic                        hs_oe;
      logic                        fi_o;
      logic                        fi_oe;
   } pvc_cap_st_t;

   pvc_cap_st_t s;
   pvc_cap_st_t n;
   pvc_trs_if   trs ();

   logic        pe;
   logic        emb_on;
   logic        dir_out;
   logic        hs_inv;
   logic        hs_gen;
   logic        vs_gen;
   logic        hs_int;
   logic        vs_int;
   logic        fld;
   logic [15:0] vstart;
   logic        in_h;
   logic        in_v;
   logic        wen_ok;
   logic        hs_fall;
   logic        vs_rise;
   logic        cap;
   logic [15:0] din;
   logic [15:0] raw_px;
   logic [15:0] px;
   logic [15:0] pxm;
   logic [1:0]  pack;
   logic [5:0]  pw;
   logic [5:0]  nb;
   logic [47:0] acc_in;
   logic        push;
   logic        push_ok;
   logic        pop;

   ////////////////////////////////////////////////////////////////////////////////
   // Pixel timing and sync selection.

   assign pe = s.mode[pvc_pkg::MODE_PIXEL_CLOCK_EDGE_INVERT] ? (!s.pc2 && s.pc3) : (s.pc2 && !s.pc3);
   assign emb_on = s.emb[pvc_pkg::EMB_ON];
   assign dir_out = s.mode[pvc_pkg::MODE_SYNC_DIR];
   assign hs_inv = s.mode[pvc_pkg::MODE_HS_INV];
   assign hs_gen = s.gh < s.htim[15:0];
   assign vs_gen = s.gv < s.vtim[15:0];

   // Embedded mode ignores the sync pins; the decoded flags act as the syncs.
   assign hs_int = emb_on ? trs.h : dir_out ? hs_gen : (s.hs2 ^ hs_inv);
   assign vs_int = emb_on ? trs.v :
                   dir_out ? vs_gen : (s.vs2 ^ s.mode[pvc_pkg::MODE_VS_INV]);

   always_comb begin
      if (emb_on) begin
         fld = trs.f;
      end else if (s.mode[pvc_pkg::MODE_FI_DIR]) begin
         fld = s.gfld;
      end else if (!s.mode[pvc_pkg::MODE_ILACE]) begin
         fld = 1'b0;
      end else if (s.mode[pvc_pkg::MODE_FI_LATCH]) begin
         fld = s.fld_lat;
      end else begin
         fld = s.wf2 ^ s.mode[pvc_pkg::MODE_FI_INV];
      end
   end

   assign vstart = fld ? s.vst[31:16] : s.vst[15:0];
   assign in_h = (s.hpos >= s.act[15:0]) &&
                 (17'(s.hpos) < (17'(s.act[15:0]) + 17'(s.act[31:16])));
   assign in_v = !vs_int && (s.vline >= vstart);
   assign wen_ok = !s.mode[pvc_pkg::MODE_WEN_EN] || s.wf2;
   assign hs_fall = pe && s.hs_p && !hs_int;
   assign vs_rise = pe && !s.vs_p && vs_int;
   assign cap = pe && !hs_fall && in_h && in_v && wen_ok &&
                s.sync[pvc_pkg::SYNC_MEMORY_WRITE_ENABLE];

   ////////////////////////////////////////////////////////////////////////////////
   // Pixel formatting and packing.

   assign din = s.d2 ^ {16{s.mode[pvc_pkg::MODE_DATA_INV]}};
   assign raw_px = 16'(din[11:0] >> s.fmt[2:0]);
   assign px = !emb_on ? raw_px :
               s.emb[pvc_pkg::EMB_W10] ? {6'h00, din[9:0]} : {8'h00, din[7:0]};
   assign pack = s.fmt[pvc_pkg::FMT_PACK_LSB +: 2];

   always_comb begin
      unique case (pack)
         pvc_pkg::PACK_8: begin
            pw = pvc_pkg::PW_8;
            pxm = {8'h00, px[7:0]};
         end
         pvc_pkg::PACK_12: begin
            pw = pvc_pkg::PW_12;
            pxm = {4'h0, px[11:0]};
         end
         default: begin
            pw = pvc_pkg::PW_16;
            pxm = px;
         end
      endcase
   end

   // Pixels fill the accumulator from bit 0 upward, so pixel 0 lands lowest
   // and a 12-bit pixel may straddle two words.
   assign acc_in = s.acc | (48'(pxm) << s.bits);
   assign nb = s.bits + pw;
   assign push = cap && (nb >= pvc_pkg::BITS_WORD);
   assign push_ok = push && (s.cnt < (AW + 1)'(FIFO_DEPTH));
   assign pop = s.bact;

   assign trs.code = s.emb[pvc_pkg::EMB_W10] ? din[9:2] : din[7:0];
   assign trs.valid = pe && emb_on;
   assign trs.ecc_en = s.emb[pvc_pkg::EMB_ECC];

   pvc_trs_decoder u_trs (
      .clk (clk),
      .rst (rst),
      .trs (trs)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      n = s;
      n.pc1 = pclk_pin;
      n.pc2 = s.pc1;
      n.pc3 = s.pc2;
      n.d1 = data_pin;
      n.d2 = s.d1;
      n.vs1 = vsync_pin;
      n.vs2 = s.vs1;
      n.hs1 = hsync_pin;
      n.hs2 = s.hs1;
      n.wf1 = wen_field_pin;
      n.wf2 = s.wf1;
      if (reg_wr) begin
         unique case (reg_addr)
            pvc_pkg::REG_MODE:   n.mode = reg_wdata[9:0];
            pvc_pkg::REG_SYNC:   n.sync = reg_wdata[1:0];
            pvc_pkg::REG_HTIM:   n.htim = reg_wdata;
            pvc_pkg::REG_VTIM:   n.vtim = reg_wdata;
            pvc_pkg::REG_ACT:    n.act = reg_wdata;
            pvc_pkg::REG_VSTART: n.vst = reg_wdata;
            pvc_pkg::REG_FMT:    n.fmt = reg_wdata[5:0];
            pvc_pkg::REG_EMB:    n.emb = reg_wdata[2:0];
            pvc_pkg::REG_BASE:   n.base = reg_wdata;
            pvc_pkg::REG_LOFF:   n.loff = reg_wdata;
            pvc_pkg::REG_FOFF:   n.foff = reg_wdata;
            default: ;
         endcase
      end
      n.rdata = pvc_pkg::RST_REG;
      if (reg_rd) begin
         unique case (reg_addr)
            pvc_pkg::REG_MODE:   n.rdata = 32'(s.mode);
            pvc_pkg::REG_SYNC:   n.rdata = 32'(s.sync);
            pvc_pkg::REG_HTIM:   n.rdata = s.htim;
            pvc_pkg::REG_VTIM:   n.rdata = s.vtim;
            pvc_pkg::REG_ACT:    n.rdata = s.act;
            pvc_pkg::REG_VSTART: n.rdata = s.vst;
            pvc_pkg::REG_FMT:    n.rdata = 32'(s.fmt);
            pvc_pkg::REG_EMB:    n.rdata = 32'(s.emb);
            pvc_pkg::REG_BASE:   n.rdata = s.base;
            pvc_pkg::REG_LOFF:   n.rdata = s.loff;
            pvc_pkg::REG_FOFF:   n.rdata = s.foff;
            pvc_pkg::REG_STAT:   n.rdata = 32'({fld, vs_int, hs_int, s.cnt});
            default: ;
         endcase
      end
      // Sync generator, counting pixel clock edges.
      if (pe && s.sync[pvc_pkg::SYNC_GEN_EN]) begin
         if ((17'(s.gh) + 17'h0_0001) >= 17'(s.htim[31:16])) begin
            n.gh = 16'h0000;
            if ((17'(s.gv) + 17'h0_0001) >= 17'(s.vtim[31:16])) begin
               n.gv = 16'h0000;
               n.gfld = !s.gfld;
            end else begin
               n.gv = s.gv + 16'h0001;
            end
         end else begin
            n.gh = s.gh + 16'h0001;
         end
      end
      // Line and frame tracking.
      if (pe) begin
         n.hs_p = hs_int;
         n.vs_p = vs_int;
         n.hpos = s.hpos + 16'h0001;
      end
      if (hs_fall) begin
         n.hpos = 16'h0000;
         n.vline = s.vline + 16'h0001;
         n.acc = 48'h0000_0000_0000;
         n.bits = 6'h00;
         if (s.lhad) begin
            n.laddr = s.laddr + s.loff;
            n.waddr = s.laddr + s.loff;
            n.lhad = 1'b0;
         end
      end
      if (vs_rise) begin
         n.vline = 16'h0000;
         n.fld_lat = s.wf2 ^ s.mode[pvc_pkg::MODE_FI_INV];
         n.laddr = s.base + (fld ? s.foff : pvc_pkg::RST_REG);
         n.waddr = s.base + (fld ? s.foff : pvc_pkg::RST_REG);
         n.lhad = 1'b0;
      end
      if (cap) begin
         n.lhad = 1'b1;
         if (push) begin
            n.acc = acc_in >> 32;
            n.bits = nb - pvc_pkg::BITS_WORD;
            n.waddr = s.waddr + pvc_pkg::WORD_BYTES;
         end else begin
            n.acc = acc_in;
            n.bits = nb;
         end
      end
      if (push_ok) begin
         n.mem[s.wp] = {s.waddr, acc_in[31:0]};
         n.wp = s.wp + AW'(1);
      end
      // Burst engine: eight back-to-back words, then at least one idle cycle.
      n.mbs = 1'b0;
      n.mv = 1'b0;
      if (s.bact) begin
         n.mv = 1'b1;
         n.mbs = (s.bcnt == 3'h0);
         n.maddr = s.mem[s.rp][63:32];
         n.mdata = s.mem[s.rp][31:0];
         n.rp = s.rp + AW'(1);
         n.bcnt = s.bcnt + 3'h1;
         n.bact = (s.bcnt != 3'(pvc_pkg::BURST_WORDS - 1));
      end else if (s.cnt >= (AW + 1)'(pvc_pkg::BURST_WORDS)) begin
         n.bact = 1'b1;
         n.bcnt = 3'h0;
      end
      n.cnt = s.cnt + (AW + 1)'(push_ok) - (AW + 1)'(pop);
      // Pin drivers.
      n.vs_oe = dir_out && !emb_on;
      n.hs_oe = dir_out && !emb_on;
      n.vs_o = vs_gen ^ s.mode[pvc_pkg::MODE_VS_INV];
      n.hs_o = hs_gen ^ hs_inv;
      n.fi_o = s.gfld ^ s.mode[pvc_pkg::MODE_FI_INV];
      // The pin is shared with write enable, so the field driver yields to it.
      n.fi_oe = s.mode[pvc_pkg::MODE_FI_DIR] && !s.mode[pvc_pkg::MODE_WEN_EN] && !emb_on;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign reg_rdata = s.rdata;
   assign vsync_drive = s.vs_o;
   assign vsync_drive_en = s.vs_oe;
   assign hsync_drive = s.hs_o;
   assign hsync_drive_en = s.hs_oe;
   assign field_drive = s.fi_o;
   assign field_drive_en = s.fi_oe;
   assign mem_valid = s.mv;
   assign mem_burst_start = s.mbs;
   assign mem_addr = s.maddr;
   assign mem_data = s.mdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_hsync_gen;
      @(posedge clk) disable iff (rst)
      (dir_out && !emb_on && s.gh == 16'h0000 && s.htim[15:0] != 16'h0000)
         |=> hsync_drive_en && (hsync_drive == !$past(hs_inv));
   endproperty
   a_hsync_gen: assert property (p_hsync_gen) else $error("generated hsync not active");

   property p_wen_gate;
      @(posedge clk) disable iff (rst)
      (push && s.mode[pvc_pkg::MODE_WEN_EN]) |-> s.wf2;
   endproperty
   a_wen_gate: assert property (p_wen_gate) else $error("word stored without write enable");

   property p_memory_write_enable_gate;
      @(posedge clk) disable iff (rst)
      !s.sync[pvc_pkg::SYNC_MEMORY_WRITE_ENABLE] |-> !push_ok;
   endproperty
   a_memory_write_enable_gate: assert property (p_memory_write_enable_gate) else $error("word stored while writes off");

   property p_burst;
      @(posedge clk) disable iff (rst)
      $rose(mem_valid) |-> mem_burst_start ##1 (mem_valid && !mem_burst_start) [*7]
         ##1 !mem_valid;
   endproperty
   a_burst: assert property (p_burst) else $error("burst is not eight words");
endmodule : pvc_capture
`default_nettype wire

/* pvc_imager_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pvc_imager_model (
   input  wire logic       run,
   input  wire logic [7:0] pat,
   output logic            pclk,
   output logic [15:0]     data,
   output logic            vsync,
   output logic            hsync
);
   int hp;
   int ln;
   initial begin
      pclk = 1'b0;
      vsync = 1'b0;
      hsync = 1'b0;
      hp = 0;
      ln = 0;
      data = 16'h0000;
      forever begin
         if (run) begin
            #100 pclk = 1'b1;
            // Data and syncs move on the falling edge, so they stand still across the rising one.
            #100 pclk = 1'b0;
            hp = (hp == 47) ? 0 : hp + 1;
            if (hp == 0) ln = (ln == 3) ? 0 : ln + 1;
            hsync = (hp < 2);
            vsync = (ln == 0);
            data = {4'h0, pat + 8'(hp), 4'h0};
         end else begin
            // Between frames the bus is inverted every 200 ns, so it never repeats its last value.
            #200 data = ~data;
         end
      end
   end
endmodule : pvc_imager_model
`default_nettype wire

/* pvc_capture_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pvc_capture_tb_top;
   logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wen = 1'b0, run = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0000_0000, rd, reg_rdata, mem_addr, mem_data, pa, pd;
   logic [7:0]  pat = 8'h00;
   logic [15:0] data;
   logic        pclk, vs, hs, vd, hd, vde, hde, mem_valid, mbs, vs_w, hs_w, fd, fde;
   int          n_fail = 0, tests_run = 0, nw = 0, run_len = 0;
   int          seed = 32'hfc979e61;
   always #12.5 clk = ~clk;
   assign vs_w = vde ? vd : vs;
   assign hs_w = hde ? hd : hs;
   pvc_imager_model i_img (.run(run), .pat(pat), .pclk(pclk), .data(data), .vsync(vs),
                           .hsync(hs));
   pvc_capture i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pclk_pin(pclk),
      .data_pin(data), .vsync_pin(vs_w), .vsync_drive(vd), .vsync_drive_en(vde),
      .hsync_pin(hs_w), .hsync_drive(hd), .hsync_drive_en(hde), .wen_field_pin(wen),
      .field_drive(fd), .field_drive_en(fde), .mem_valid(mem_valid), .mem_burst_start(mbs),
      .mem_addr(mem_addr), .mem_data(mem_data));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdt(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rdt
   task automatic frame();
      nw = 0;
      run <= 1'b1;
      repeat (1700) @(posedge clk);
      run <= 1'b0;
      repeat (20) @(posedge clk);
   endtask : frame
   function automatic logic [31:0] exp_word(input logic [7:0] b);
      return {b + 8'h03, b + 8'h02, b + 8'h01, b};
   endfunction : exp_word
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (mem_valid === 1'b1) begin
         check({31'h0000_0000, mbs}, {31'h0000_0000, run_len == 0});
         if (run_len != 0) begin
            check(mem_addr, pa + pvc_pkg::WORD_BYTES);
            check({24'h00_0000, mem_data[7:0]}, {24'h00_0000, pd[31:24] + 8'h01});
         end
         check(mem_data, exp_word(mem_data[7:0]));
         pa = mem_addr;
         pd = mem_data;
         nw++;
         run_len++;
      end else if (run_len != 0) begin
         check(32'(run_len), 32'h0000_0008);
         run_len = 0;
      end
   end
   initial begin
      #1000000 n_fail++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      pat <= 8'($random(seed));
      rdt(pvc_pkg::REG_SYNC, rd);
      check(rd, pvc_pkg::RST_REG);
      wr(pvc_pkg::REG_FMT, 32'h0000_0024);
      wr(pvc_pkg::REG_ACT, {16'h0020, 16'h0002 + 16'($random(seed) & 3)});
      wr(pvc_pkg::REG_BASE, 32'($random(seed)) & 32'h0fff_ff00);
      wr(pvc_pkg::REG_LOFF, 32'h0000_0100);
      wr(pvc_pkg::REG_MODE, 32'h0000_0020);
      rdt(pvc_pkg::REG_FMT, rd);
      check(rd, 32'h0000_0024);
      rdt(6'h30, rd);
      check(rd, pvc_pkg::RST_REG);
      frame();
      check(32'(nw), 32'h0000_0000);
      wr(pvc_pkg::REG_SYNC, 32'h0000_0002);
      frame();
      check(32'(nw), 32'h0000_0000);
      wen <= 1'b1;
      frame();
      check({31'h0000_0000, nw >= 16}, 32'h0000_0001);
      wr(pvc_pkg::REG_MODE, 32'h0000_0001);
      wr(pvc_pkg::REG_HTIM, {16'h000a, 16'h0002});
      wr(pvc_pkg::REG_VTIM, {16'h0004, 16'h0001});
      wr(pvc_pkg::REG_SYNC, 32'h0000_0001);
      repeat (10) @(posedge clk);
      check({30'h0000_0000, vde, hde}, 32'h0000_0003);
      // With the pixel clock stopped both generator counts sit at zero, inside the pulses.
      check({30'h0000_0000, vd, hd}, 32'h0000_0003);
      check({30'h0000_0000, fde, fd}, 32'h0000_0000);
      end_sim();
   end
endmodule : pvc_capture_tb_top
`default_nettype wire
